// file: src/sensor_port_host.sv
// Purpose: Host end: one register read or write over SPI or I2C.
// Assumes: mclk at 125 MHz; serial clock divided down from it.
// Notes:   Outputs to the pins are registered, one cycle behind the state.

`timescale 1ns/10ps

module sensor_port_host (
  input  wire logic       mclk,      // System clock
  input  wire logic       nrst,      // Sync reset, active low
  input  wire logic       useI2c,    // Select I2C link (else SPI)
  input  wire logic       cpolHigh,  // SPI idle clock high (mode 3)
  input  wire logic [1:0] strapAddr, // Device address strap bits
  input  wire logic       reqValid,  // Request offered
  output logic            reqReady,  // Request taken when both high
  input  wire logic       reqWrite,  // 1 write, 0 read
  input  wire logic [6:0] reqAddr,   // Register address
  input  wire logic [7:0] reqData,   // Write data
  output logic            rspValid,  // One-cycle answer pulse
  output logic [7:0]      rspData,   // Read data
  output logic [7:0]      rspStatus, // Status byte (SPI)
  output logic            rspNack,   // I2C not acknowledged
  serial_port_if.host     port       // Pins
);

  serial_port_pkg::host_state_type state_r;
  logic [15:0] div_r;
  logic        tick;
  logic [1:0]  byteIdx_r;
  logic [3:0]  bitIdx_r;
  logic [7:0]  rx_r;
  logic        i2c_r;
  logic        cpol_r;
  logic        wr_r;
  logic [6:0]  addr_r;
  logic [7:0]  data_r;
  logic [1:0]  dataSync_r;
  logic [1:0]  misoSync_r;
  logic [7:0]  txCur;
  logic [1:0]  lastIdx;
  logic [3:0]  lastBit;
  logic        txBit;
  logic        ownByte;
  logic        sampled;
  logic        sclkNxt;
  logic        selNxt;
  logic        sdaLowNxt;

  ////////////////////////////////////////////////////////////////////////
  // Timing and input sampling

  assign tick = div_r == 16'(serial_port_pkg::SCLK_HALF_CYC - 1);

  always_ff @(posedge mclk)
  begin
    if (!nrst || state_r == serial_port_pkg::H_IDLE || tick)
      div_r <= '0;
    else
      div_r <= div_r + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dataSync_r <= 2'b11;
      misoSync_r <= 2'b11;
    end
    else
    begin
      dataSync_r <= {dataSync_r[0], port.dataLine};
      misoSync_r <= {misoSync_r[0], port.misoLine};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte plan

  always_comb
  begin
    txCur = serial_port_pkg::IDLE_BYTE;
    if (!i2c_r)
      txCur = (byteIdx_r == 2'd0) ? {~wr_r, addr_r} :
              (wr_r ? data_r : 8'h00);
    else
      case (byteIdx_r)
        2'd0: txCur = {serial_port_pkg::I2C_ADDR_HI, strapAddr, 1'b0};
        2'd1: txCur = {1'b0, addr_r};
        2'd2: txCur = wr_r ? data_r
                           : {serial_port_pkg::I2C_ADDR_HI, strapAddr, 1'b1};
        default: txCur = serial_port_pkg::IDLE_BYTE;
      endcase
  end

  assign lastIdx = !i2c_r ? 2'd1 : (wr_r ? 2'd2 : 2'd3);
  assign lastBit = i2c_r ? serial_port_pkg::ACK_SLOT
                         : serial_port_pkg::LAST_BIT;
  assign ownByte = !(i2c_r && !wr_r && byteIdx_r == 2'd3);
  assign txBit   = (bitIdx_r > serial_port_pkg::LAST_BIT) ? 1'b1 :
                   txCur[3'(serial_port_pkg::LAST_BIT - bitIdx_r)];
  assign sampled = i2c_r ? dataSync_r[1] : misoSync_r[1];
  assign reqReady = state_r == serial_port_pkg::H_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r   <= serial_port_pkg::H_IDLE;
      byteIdx_r <= '0;
      bitIdx_r  <= '0;
      rx_r      <= '0;
      i2c_r     <= 1'b0;
      cpol_r    <= 1'b0;
      wr_r      <= 1'b0;
      addr_r    <= '0;
      data_r    <= '0;
      rspValid  <= 1'b0;
      rspData   <= '0;
      rspStatus <= '0;
      rspNack   <= 1'b0;
    end
    else
    begin
      rspValid <= 1'b0;
      case (state_r)
        serial_port_pkg::H_IDLE:
        begin
          i2c_r  <= useI2c;
          cpol_r <= cpolHigh;
          if (reqValid)
          begin
            wr_r      <= reqWrite;
            addr_r    <= reqAddr;
            data_r    <= reqData;
            byteIdx_r <= '0;
            bitIdx_r  <= '0;
            rspNack   <= 1'b0;
            state_r   <= useI2c ? serial_port_pkg::H_START
                                : serial_port_pkg::H_SEL;
          end
        end
        serial_port_pkg::H_SEL, serial_port_pkg::H_START:
          if (tick)
            state_r <= serial_port_pkg::H_LO;
        serial_port_pkg::H_RS:
          if (tick)
            state_r <= serial_port_pkg::H_START;
        // Sampled just before the rise: the device moves on right after it
        serial_port_pkg::H_LO:
          if (tick)
          begin
            if (bitIdx_r <= serial_port_pkg::LAST_BIT)
              rx_r <= {rx_r[6:0], sampled};
            state_r <= serial_port_pkg::H_HI;
          end
        serial_port_pkg::H_HI:
          if (tick)
          begin
            if (bitIdx_r != lastBit)
            begin
              bitIdx_r <= bitIdx_r + 4'h1;
              state_r  <= serial_port_pkg::H_LO;
            end
            else
            begin
              bitIdx_r <= '0;
              if (!i2c_r && byteIdx_r == 2'd0)
                rspStatus <= rx_r;
              else if (!i2c_r || byteIdx_r == 2'd3)
                rspData <= rx_r;
              if (i2c_r && ownByte && sampled)
              begin
                rspNack <= 1'b1;
                state_r <= serial_port_pkg::H_STOP_LO;
              end
              else if (byteIdx_r == lastIdx)
                state_r <= i2c_r ? serial_port_pkg::H_STOP_LO
                                 : serial_port_pkg::H_END;
              else
              begin
                byteIdx_r <= byteIdx_r + 2'd1;
                state_r   <= (i2c_r && !wr_r && byteIdx_r == 2'd1)
                             ? serial_port_pkg::H_RS : serial_port_pkg::H_LO;
              end
            end
          end
        serial_port_pkg::H_STOP_LO:
          if (tick)
            state_r <= serial_port_pkg::H_STOP_HI;
        serial_port_pkg::H_STOP_HI:
          if (tick)
            state_r <= serial_port_pkg::H_END;
        serial_port_pkg::H_END:
          if (tick)
          begin
            rspValid <= 1'b1;
            state_r  <= serial_port_pkg::H_IDLE;
          end
        default:
          state_r <= serial_port_pkg::H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive, registered one cycle after the state

  always_comb
  begin
    sclkNxt   = i2c_r | cpol_r;
    selNxt    = 1'b0;
    sdaLowNxt = 1'b0;
    case (state_r)
      serial_port_pkg::H_SEL:
        selNxt = ~i2c_r;
      serial_port_pkg::H_LO:
      begin
        sclkNxt   = 1'b0;
        selNxt    = ~i2c_r;
        sdaLowNxt = ownByte & ~txBit;
      end
      serial_port_pkg::H_HI:
      begin
        sclkNxt   = 1'b1;
        selNxt    = ~i2c_r;
        sdaLowNxt = ownByte & ~txBit;
      end
      serial_port_pkg::H_RS:
        sclkNxt = 1'b0;
      serial_port_pkg::H_START, serial_port_pkg::H_STOP_HI:
      begin
        sclkNxt   = 1'b1;
        sdaLowNxt = 1'b1;
      end
      serial_port_pkg::H_STOP_LO:
      begin
        sclkNxt   = 1'b0;
        sdaLowNxt = 1'b1;
      end
      default:
        ;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      port.linkClk <= 1'b0;
      port.ssnHost <= 1'b1;
      port.hostOut <= 1'b1;
      port.hostOe  <= 1'b0;
      port.selI2c  <= 1'b0;
    end
    else
    begin
      port.selI2c  <= (state_r == serial_port_pkg::H_IDLE) ? useI2c
                                                           : i2c_r;
      port.linkClk <= sclkNxt;
      port.ssnHost <= ~selNxt;
      port.hostOut <= i2c_r ? 1'b0 : txBit;
      port.hostOe  <= i2c_r ? sdaLowNxt : selNxt;
    end
  end

endmodule

// file: common/serial_port_pkg.sv
// Purpose: Shared constants and types for the sensor host serial port.
// Assumes: Host side runs on mclk at 125 MHz; device side on the link clock.
// Notes:   Register indices below are 7-bit register addresses.

package serial_port_pkg;

  localparam int CLK_MHZ      = 125;
  // Fastest serial clock the master may make
  localparam int SCLK_MAX_KHZ = 1000;
  // Half period in mclk cycles, rounded up so the clock never runs fast
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

  localparam logic [4:0] I2C_ADDR_HI = 5'h08;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  localparam int         DR_BIT      = 7;

  localparam logic [6:0] STATUS_IDX  = 7'h10;
  localparam logic [6:0] RESULT_BASE = 7'h11;
  localparam logic [7:0] IDLE_BYTE   = 8'hFF;

  typedef enum {P_FIRST, P_REG, P_WR, P_RD, P_SKIP} link_phase_type;

  typedef enum {H_IDLE, H_SEL, H_RS, H_START, H_LO, H_HI,
                H_STOP_LO, H_STOP_HI, H_END} host_state_type;

endpackage

// file: common/serial_port_if.sv
// Purpose: Pins between host and sensor port; resolves shared lines.
// Assumes: Testbench drives the two address strap levels.
// Notes:   Data line is wired-AND with a pull-up; MISO pin carries strap 1
//          whenever the device does not drive it.

`timescale 1ns/10ps

interface serial_port_if;
  logic linkClk;    // SCLK / SCL, made by the host
  logic selI2c;     // Interface select level, tied by the host board
  logic ssnHost;    // Host slave select, SPI only
  logic hostOut;    // Host data drive value
  logic hostOe;     // Host data drive enable
  logic devOut;     // Device data drive value
  logic devOe;      // Device data drive enable
  logic misoOut;    // Device MISO value
  logic misoOe;     // Device MISO enable
  logic strap0;     // Board level on the select pin in I2C mode
  logic strap1;     // Board level on the MISO pin in I2C mode
  logic dataLine;   // Resolved MOSI / SDA
  logic ssnLine;    // Resolved select / strap bit 0
  logic misoLine;   // Resolved MISO / strap bit 1

  assign dataLine = (hostOe ? hostOut : 1'b1) & (devOe ? devOut : 1'b1);
  assign ssnLine  = selI2c ? strap0 : ssnHost;
  assign misoLine = misoOe ? misoOut : strap1;

  modport device (input linkClk, selI2c, dataLine, ssnLine, misoLine,
                  output devOut, devOe, misoOut, misoOe);
  modport host (input dataLine, misoLine,
                output linkClk, selI2c, ssnHost, hostOut, hostOe);
endinterface

// file: src/sensor_port_device.sv
// Purpose: Device end of the sensor serial port, SPI or I2C slave.
// Assumes: Link logic runs on the host's serial clock; measurement side on
//          mclk. Select level only changes while the link is quiet.
// Notes:   Operation
// Operation
// - Select high means I2C, low means SPI.
// - Data-ready rises when a measurement completes.
// - Result read or any write drops data-ready.
// - Status and idle MISO show data available.
// - Bytes move MSB first; master samples rising.
// - Master shifts MOSI on falling edges.
// - One byte takes exactly eight clocks.
// - Master keeps serial clock at most 1 MHz.
// - Select falls before and stays low throughout.
// - MISO floats while not selected.
// - Measurement continues while not selected.
// - I2C address is 01000 plus two straps.
// - I2C uses one data line, MSB first.
// - I2C master clock at most 1 MHz.
// - Registers kept while analog supply is off.
// - First byte is R/W plus address; auto-increment.
// - SPI idles low or high, modes 0 and 3.
// - Select rising mid-transfer aborts it.

`timescale 1ns/10ps

module sensor_port_device #(
  parameter int NREG = 16,   // Writable registers at low addresses
  parameter int NRES = 6     // Result bytes above RESULT_BASE
) (
  input  wire logic              mclk,          // Measurement clock
  input  wire logic              nrst,          // Reset, active low; sync on the mclk side, async on the link side
  input  wire logic              measDone,      // Measurement done pulse
  input  wire logic              analogSupply,  // Analog supply is on
  input  wire logic [8*NRES-1:0] resultIn,      // Result bytes, byte 0 low
  output logic                   dataReadyLine, // Fresh data to read
  serial_port_if.device          port           // Host-facing pins
);

  ////////////////////////////////////////////////////////////////////////
  // Measurement side

  logic              dataReady_r;
  logic [8*NRES-1:0] resultHold_r;
  logic [1:0]        clrSync_r;
  logic              clrAck_r;
  logic              clrReq_r;
  logic              measOk;
  logic              clrEvt;

  // No result may land without the analog supply
  assign measOk = measDone & analogSupply;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      resultHold_r <= '0;
    else if (measOk)
      resultHold_r <= resultIn;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      clrSync_r <= '0;
      clrAck_r  <= 1'b0;
    end
    else
    begin
      clrSync_r <= {clrSync_r[0], clrReq_r};
      clrAck_r  <= clrSync_r[1];
    end
  end

  assign clrEvt = clrSync_r[1] & ~clrAck_r;

  // Runs regardless of selection; a completion beats a clear
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      dataReady_r <= 1'b0;
    else if (measOk)
      dataReady_r <= 1'b1;
    else if (clrEvt)
      dataReady_r <= 1'b0;
  end

  assign dataReadyLine = dataReady_r;

  ////////////////////////////////////////////////////////////////////////
  // Link side

  logic                i2cMode;
  logic                startHeld_r;
  logic                stopHeld_r;
  logic                frameClr;
  logic                rstLink;
  logic                reqClr;
  logic [1:0]          drSync_r;
  serial_port_pkg::link_phase_type phase_r;
  logic [3:0]          cnt_r;
  logic [7:0]          shift_r;
  logic [6:0]          regAddr_r;
  logic                devAck_r;
  logic                sdaLow_r;
  logic [7:0]          regs_r [NREG];
  logic [7:0]          rxByte;
  logic [7:0]          statusByte;
  logic [7:0]          rdByte;
  logic [7:0]          txByte;
  logic                isResult;
  logic                byteEnd;
  logic                wrEvt;
  logic                rdEvt;
  logic                addrMatch;

  assign i2cMode = port.selI2c;
  assign rstLink = ~nrst;
  assign reqClr  = clrAck_r | ~nrst;

  // Start: data falls with clock high; held until the clock falls
  always_ff @(negedge port.dataLine or negedge port.linkClk)
  begin
    if (!port.linkClk)
      startHeld_r <= 1'b0;
    else
      startHeld_r <= 1'b1;
  end

  // Stop: data rises with clock high
  always_ff @(posedge port.dataLine or negedge port.linkClk)
  begin
    if (!port.linkClk)
      stopHeld_r <= 1'b0;
    else
      stopHeld_r <= 1'b1;
  end

  // The link clock stops between frames, so a frame ends on its own signal
  assign frameClr = rstLink | (i2cMode ? (startHeld_r | stopHeld_r)
                                       : port.ssnLine);

  always_ff @(posedge port.linkClk or posedge rstLink)
  begin
    if (rstLink)
      drSync_r <= '0;
    else
      drSync_r <= {drSync_r[0], dataReady_r};
  end

  always_comb
  begin
    statusByte = '0;
    statusByte[serial_port_pkg::DR_BIT] = drSync_r[1];
  end

  always_comb
  begin
    rdByte   = '0;
    isResult = 1'b0;
    if (regAddr_r == serial_port_pkg::STATUS_IDX)
      rdByte = statusByte;
    else if (regAddr_r >= serial_port_pkg::RESULT_BASE &&
             int'(regAddr_r) < int'(serial_port_pkg::RESULT_BASE) + NRES)
    begin
      isResult = 1'b1;
      rdByte   = resultHold_r[8 * int'(regAddr_r -
                              serial_port_pkg::RESULT_BASE) +: 8];
    end
    else if (int'(regAddr_r) < NREG)
      rdByte = regs_r[int'(regAddr_r)];
  end

  assign rxByte    = {shift_r[6:0], port.dataLine};
  assign byteEnd   = cnt_r == serial_port_pkg::LAST_BIT;
  assign wrEvt     = byteEnd & (phase_r == serial_port_pkg::P_WR);
  assign rdEvt     = byteEnd & (phase_r == serial_port_pkg::P_RD);
  assign addrMatch = rxByte[7:1] == {serial_port_pkg::I2C_ADDR_HI,
                                     port.misoLine, port.ssnLine};

  always_ff @(posedge port.linkClk or posedge frameClr)
  begin
    if (frameClr)
    begin
      phase_r  <= serial_port_pkg::P_FIRST;
      cnt_r    <= '0;
      shift_r  <= '0;
      devAck_r <= 1'b0;
    end
    else
    begin
      shift_r <= rxByte;
      if (i2cMode && cnt_r == serial_port_pkg::ACK_SLOT)
      begin
        cnt_r <= '0;
        if (phase_r == serial_port_pkg::P_RD && port.dataLine)
          phase_r <= serial_port_pkg::P_SKIP;
      end
      else if (byteEnd)
      begin
        cnt_r    <= i2cMode ? serial_port_pkg::ACK_SLOT : 4'h0;
        devAck_r <= 1'b0;
        case (phase_r)
          serial_port_pkg::P_FIRST:
            if (!i2cMode)
              phase_r <= rxByte[7] ? serial_port_pkg::P_RD
                                   : serial_port_pkg::P_WR;
            else if (addrMatch)
            begin
              devAck_r <= 1'b1;
              phase_r  <= rxByte[0] ? serial_port_pkg::P_RD
                                    : serial_port_pkg::P_REG;
            end
            else
              phase_r <= serial_port_pkg::P_SKIP;
          serial_port_pkg::P_REG:
          begin
            devAck_r <= 1'b1;
            phase_r  <= serial_port_pkg::P_WR;
          end
          serial_port_pkg::P_WR:
            devAck_r <= 1'b1;
          default:
            ;
        endcase
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end

  // Kept across a repeated start so a read follows its address write
  always_ff @(posedge port.linkClk or posedge rstLink)
  begin
    if (rstLink)
      regAddr_r <= '0;
    else if (byteEnd && !frameClr)
      case (phase_r)
        serial_port_pkg::P_FIRST:
          if (!i2cMode)
            regAddr_r <= rxByte[6:0];
        serial_port_pkg::P_REG:
          regAddr_r <= rxByte[6:0];
        serial_port_pkg::P_WR, serial_port_pkg::P_RD:
          regAddr_r <= regAddr_r + 7'h01;
        default:
          ;
      endcase
  end

  // Storage has no reset so that contents ride through supply cycling
  always_ff @(posedge port.linkClk)
  begin
    if (wrEvt && int'(regAddr_r) < NREG)
      regs_r[int'(regAddr_r)] <= rxByte;
  end

  always_ff @(posedge port.linkClk or posedge reqClr)
  begin
    if (reqClr)
      clrReq_r <= 1'b0;
    else if (wrEvt || (rdEvt && isResult))
      clrReq_r <= 1'b1;
  end

  // MISO changes just after each rising edge, so both idle levels work
  assign txByte = (phase_r == serial_port_pkg::P_FIRST) ? statusByte :
                  (phase_r == serial_port_pkg::P_RD) ? rdByte
                                                     : 8'h00;
  assign port.misoOut = txByte[3'(serial_port_pkg::LAST_BIT - cnt_r)];
  assign port.misoOe  = ~i2cMode & ~port.ssnLine;

  // I2C drive changes only while the clock is low
  always_ff @(negedge port.linkClk or posedge frameClr)
  begin
    if (frameClr)
      sdaLow_r <= 1'b0;
    else if (!i2cMode)
      sdaLow_r <= 1'b0;
    else if (cnt_r == serial_port_pkg::ACK_SLOT)
      sdaLow_r <= devAck_r;
    else if (phase_r == serial_port_pkg::P_RD)
      sdaLow_r <= ~rdByte[3'(serial_port_pkg::LAST_BIT - cnt_r)];
    else
      sdaLow_r <= 1'b0;
  end

  assign port.devOut = 1'b0;
  assign port.devOe  = sdaLow_r;

endmodule

// file: tb/sensor_host_serial_port_assertions.sv
// Purpose: Wire-level checks on the link between host and device ends.
// Assumes: Link clock is made from mclk by the host, so sampling it on
//          mclk sees every level it takes.
// Notes:   Bit and half-period counts live in small helper counters.

`timescale 1ns/10ps

module sensor_host_serial_port_assertions (
  input wire logic mclk,    // System clock
  input wire logic nrst,    // Sync reset, active low
  input wire logic linkClk, // Serial clock on the link
  input wire logic selI2c,  // Interface select level
  input wire logic ssnLine, // Resolved select line
  input wire logic hostOut, // Host data value
  input wire logic hostOe,  // Host data enable
  input wire logic devOe,   // Device data enable
  input wire logic misoOe   // Device MISO enable
);
  // One cycle of slack so a divider rounding choice is not flagged
  localparam int HALF_MIN = serial_port_pkg::SCLK_HALF_CYC - 2;

  logic       linkPrev_r;
  logic [2:0] bitCnt_r;
  logic [6:0] halfCnt_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    linkPrev_r <= linkClk;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst || ssnLine || selI2c)
      bitCnt_r <= 3'h0;
    else if (linkClk && !linkPrev_r)
      bitCnt_r <= bitCnt_r + 3'h1;
  end

  // Saturates so a long idle never wraps into a short-looking half
  always_ff @(posedge mclk)
  begin
    if (!nrst || linkClk != linkPrev_r)
      halfCnt_r <= 7'h00;
    else if (halfCnt_r != 7'h7F)
      halfCnt_r <= halfCnt_r + 7'h01;
  end

  sequence spiSelect;
    !selI2c && $fell(ssnLine);
  endsequence

  //////////////////////////////////////////////////////////////////////////
  chk_miso_float:
    assert property (ssnLine |-> !misoOe)
      else $error("MISO driven while not selected");
  chk_miso_drive:
    assert property (!selI2c && !ssnLine |-> misoOe)
      else $error("MISO not driven while selected");
  chk_spi_quiet:
    assert property (!selI2c |-> !devOe)
      else $error("data line driven by device in SPI mode");
  chk_byte_eight:
    assert property ($rose(ssnLine) && !selI2c |-> bitCnt_r == 3'h0)
      else $error("SPI frame not a whole number of bytes");
  chk_sclk_rate:
    assert property (!selI2c && !ssnLine && linkClk != linkPrev_r
                     |-> int'(halfCnt_r) >= HALF_MIN)
      else $error("serial clock half period too short");
  chk_first_setup:
    assert property (spiSelect |-> (hostOe && !$rose(linkClk)) [*8])
      else $error("first bit not set up before clock");
  chk_mosi_setup:
    assert property (!selI2c && !ssnLine && $rose(linkClk)
                     |-> hostOut == $past(hostOut, 7))
      else $error("MOSI changed just before rising edge");
  chk_mosi_hold:
    assert property (!selI2c && !ssnLine && !$past(ssnLine) && linkClk
                     && $past(linkClk) |-> $stable(hostOut))
      else $error("MOSI changed while clock high");
endmodule

// file: tb/sensor_host_serial_port_tb.sv
// Purpose: Self-checking bench joining host and device ends of the port.
// Assumes: Host makes the link clock; bench drives straps and user sides.
// Notes:   One register access per request; every wait is bounded.

`timescale 1ns/10ps

module sensor_host_serial_port_tb;
  localparam int NRES = 6;
  logic              mclk;
  logic              nrst;
  logic              measDone;
  logic              analogSupply;
  logic [8*NRES-1:0] resultIn;
  logic              dataReadyLine;
  logic              useI2c;
  logic              cpolHigh;
  logic [1:0]        strapAddr;
  logic              reqValid;
  logic              reqReady;
  logic              reqWrite;
  logic [6:0]        reqAddr;
  logic [7:0]        reqData;
  logic              rspValid;
  logic [7:0]        rspData;
  logic [7:0]        rspStatus;
  logic              rspNack;
  int                failures = 0;
  int                totalChecks = 0;
  int                cycles = 0;

  serial_port_if link ();

  sensor_port_device #(.NREG(16), .NRES(NRES)) i_sensor_port_device (
    .mclk(mclk), .nrst(nrst), .measDone(measDone),
    .analogSupply(analogSupply), .resultIn(resultIn),
    .dataReadyLine(dataReadyLine), .port(link.device));
  sensor_port_host i_sensor_port_host (
    .mclk(mclk), .nrst(nrst), .useI2c(useI2c), .cpolHigh(cpolHigh),
    .strapAddr(strapAddr), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .rspValid(rspValid), .rspData(rspData), .rspStatus(rspStatus),
    .rspNack(rspNack), .port(link.host));
  sensor_host_serial_port_assertions i_sensor_host_serial_port_assertions (
    .mclk(mclk), .nrst(nrst), .linkClk(link.linkClk),
    .selI2c(link.selI2c), .ssnLine(link.ssnLine), .hostOut(link.hostOut),
    .hostOe(link.hostOe), .devOe(link.devOe), .misoOe(link.misoOe));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A whole run needs about 25000 cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures = failures + 1;
      final_report();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Holds the request until taken, then waits for the answer pulse
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [7:0] data);
    int n;
    n = 0;
    @(negedge mclk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = addr;
    reqData = data;
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 9000)
    begin
      @(negedge mclk);
      n++;
    end
    chk1("answer given", 1'b1, rspValid);
  endtask

  task automatic pulse_meas();
    @(negedge mclk);
    measDone = 1'b1;
    @(negedge mclk);
    measDone = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_spi_rw();
    xfer(1'b1, 7'h0F, 8'h5A);
    xfer(1'b0, 7'h0F, 8'h00);
    chk8("mode0 read back", 8'h5A, rspData);
    $display("test spi_rw done");
  endtask

  task automatic t_ready();
    cpolHigh = 1'b1;
    pulse_meas();
    chk1("ready after measure", 1'b1, dataReadyLine);
    xfer(1'b0, serial_port_pkg::STATUS_IDX, 8'h00);
    chk1("status bit", 1'b1, rspData[serial_port_pkg::DR_BIT]);
    chk1("ready kept", 1'b1, dataReadyLine);
    xfer(1'b0, serial_port_pkg::RESULT_BASE, 8'h00);
    chk8("result byte", resultIn[7:0], rspData);
    chk1("status byte", 1'b1, rspStatus[serial_port_pkg::DR_BIT]);
    chk1("ready cleared by read", 1'b0, dataReadyLine);
    cpolHigh = 1'b0;
    pulse_meas();
    xfer(1'b1, 7'h20, 8'hC3);
    chk1("ready cleared by write", 1'b0, dataReadyLine);
    $display("test ready done");
  endtask

  task automatic t_i2c();
    useI2c = 1'b1;
    xfer(1'b1, 7'h05, 8'h3C);
    chk1("own address acked", 1'b0, rspNack);
    xfer(1'b0, 7'h05, 8'h00);
    chk8("i2c read back", 8'h3C, rspData);
    strapAddr = 2'b01;
    xfer(1'b0, 7'h05, 8'h00);
    chk1("other address refused", 1'b1, rspNack);
    $display("test i2c done");
  endtask

  task automatic t_retain();
    useI2c = 1'b0;
    analogSupply = 1'b0;
    pulse_meas();
    chk1("no ready unpowered", 1'b0, dataReadyLine);
    xfer(1'b0, 7'h05, 8'h00);
    chk8("register kept", 8'h3C, rspData);
    analogSupply = 1'b1;
    $display("test retain done");
  endtask

  initial
  begin
    nrst = 1'b0;
    measDone = 1'b0;
    analogSupply = 1'b1;
    resultIn = 48'h665544332211;
    useI2c = 1'b0;
    cpolHigh = 1'b0;
    strapAddr = 2'b10;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 7'h00;
    reqData = 8'h00;
    link.strap0 = 1'b0;
    link.strap1 = 1'b1;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    chk1("ready at reset", 1'b0, dataReadyLine);
    t_spi_rw();
    t_ready();
    t_i2c();
    t_retain();
    final_report();
  end
endmodule
